// ---- src/asp_fifo.sv ----
// asp_fifo: first-in first-out buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module asp_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("asp_fifo: depth must be a power of two");
  end

  logic [W-1:0] mem_r [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  wire logic    push = in_valid && in_ready;
  wire logic    pop  = out_valid && out_ready;

  assign in_ready  = (wp_r - rp_r) != (AW+1)'(D);
  assign out_valid = wp_r != rp_r;
  assign out_data  = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) mem_r[wp_r[AW-1:0]] <= in_data;
  end

endmodule : asp_fifo
`default_nettype wire

// ---- src/asp_pkg.sv ----
// asp_pkg: register map, field positions, reset values and timing
package asp_pkg;

  // ***************************************
  // register addresses
  // ***************************************
  localparam logic [7:0] ASP_FMT_ADDR  = 8'h8C;
  localparam logic [7:0] ASP_SLOT_ADDR = 8'h8D;
  localparam logic [7:0] ASP_OFSL_ADDR = 8'h8E;
  localparam logic [7:0] ASP_OFSH_ADDR = 8'h8F;
  localparam logic [7:0] ASP_CLK_ADDR  = 8'h90;
  localparam logic [7:0] ASP_STAT_ADDR = 8'h91;

  // ***************************************
  // reset values and writable bits
  // ***************************************
  localparam logic [7:0] ASP_FMT_RST   = 8'h28;
  localparam logic [7:0] ASP_SLOT_RST  = 8'h40;
  localparam logic [7:0] ASP_OFS_RST   = 8'h00;
  localparam logic [7:0] ASP_CLK_RST   = 8'h01;
  localparam logic [7:0] ASP_SLOT_WMSK = 8'hCF;
  localparam logic [7:0] ASP_OFSH_WMSK = 8'h07;
  localparam logic [7:0] ASP_CLK_WMSK  = 8'h9F;

  // ***************************************
  // field positions
  // ***************************************
  localparam int ASP_EN_BIT   = 7;
  localparam int ASP_CHN_LSB  = 4;
  localparam int ASP_WL_LSB   = 2;
  localparam int ASP_FMT_LSB  = 0;
  localparam int ASP_TDM_BIT  = 7;
  localparam int ASP_OE_BIT   = 6;
  localparam int ASP_MASK_LSB = 0;
  localparam int ASP_MST_BIT  = 7;
  localparam int ASP_WTRI_BIT = 4;
  localparam int ASP_WPOL_BIT = 3;
  localparam int ASP_BPOL_BIT = 2;
  localparam int ASP_BPW_LSB  = 0;

  // ***************************************
  // frame position counter
  // ***************************************
  localparam logic [11:0] ASP_POS_IDLE = 12'hFFE;
  localparam logic [11:0] ASP_POS_ARM  = 12'hFFF;

  // ***************************************
  // timing: master bit clock period
  // ***************************************
  localparam int ASP_CLK_KHZ   = 10000;
  localparam int ASP_BCLK_NS   = 800;
  localparam int ASP_BCLK_HALF = ASP_BCLK_NS * ASP_CLK_KHZ / 2000000;

  typedef enum logic [1:0] {
    ASP_I2S = 2'b00,
    ASP_LJ  = 2'b01,
    ASP_RJ  = 2'b10,
    ASP_DSP = 2'b11
  } asp_fmt_e;

endpackage : asp_pkg

// ---- src/asp_port.sv ----
// asp_port: audio serial port clocking, framing and slot logic
//
// Functional notes
// - shared-slot mode floats data output except while sending channel data
// - output drive bit zero floats data output; resets to one
// - four-bit mask enables channels 1L,1R,2L,2R individually in shared mode
// - low offset byte delays data by n bit clocks after frame clock
// - three-bit high offset counts delay in units of 256 bit clocks; zero none
// - master drives bit and frame clocks; slave (reset) receives both
// - force bit makes frame clock an input regardless of master bit
// - frame clock polarity bit inverts generated and received frame clock
// - bit clock polarity bit swaps launch and sample edges
// - master frame holds 32, 64, 128 or 256 bit clocks; 64 at reset
// - port enable zero stops all transfer; one enables counted channels
// - format field picks I2S, left, right justified or DSP framing
// - word width field picks 16, 20, 24 or 32 bits; 24 at reset
// - channel count enables none up to all four; codes above reserved
`timescale 1ns/10ps
`default_nettype none
module asp_port
  import asp_pkg::*;
#(
  parameter int BCLK_HALF  = ASP_BCLK_HALF,
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // transmit samples in
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  // received samples out
  output logic      [31:0] rx_data,
  output logic      [1:0]  rx_chan,
  output logic             rx_valid,
  // bit clock pin
  input  wire logic        bclk_in,
  output logic             bclk_out,
  output logic             bclk_oe_b,
  // frame clock pin
  input  wire logic        wclk_in,
  output logic             wclk_out,
  output logic             wclk_oe_b,
  // serial data pins
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             sdo_oe_b
);

  if (BCLK_HALF < 1 || FIFO_DEPTH < 2) begin : g_chk
    $error("asp_port: BCLK_HALF and FIFO_DEPTH out of range");
  end

  // ***************************************
  // helpers
  // ***************************************
  function automatic logic [11:0] wl_bits(input logic [1:0] c);
    case (c)
      2'b00:   wl_bits = 12'd16;
      2'b01:   wl_bits = 12'd20;
      2'b10:   wl_bits = 12'd24;
      default: wl_bits = 12'd32;
    endcase
  endfunction : wl_bits

  function automatic logic in_win(input logic [11:0] pos,
                                  input logic [11:0] st,
                                  input logic [11:0] wl);
    in_win = ({1'b0, pos} >= {1'b0, st}) &&
             ({1'b0, pos} < ({1'b0, st} + {1'b0, wl}));
  endfunction : in_win

  // ***************************************
  // register file
  // ***************************************
  logic [7:0] port_format_control_r;
  logic [7:0] slot_sharing_control_r;
  logic [7:0] data_offset_low_r;
  logic [7:0] data_offset_high_r;
  logic [7:0] port_clocking_control_r;
  logic [7:0] reg_rdata_r;
  logic [7:0] rd_nxt;
  logic [7:0] status_w;

  wire logic wr_fmt  = reg_wr && reg_addr == ASP_FMT_ADDR;
  wire logic wr_slot = reg_wr && reg_addr == ASP_SLOT_ADDR;
  wire logic wr_ofsl = reg_wr && reg_addr == ASP_OFSL_ADDR;
  wire logic wr_ofsh = reg_wr && reg_addr == ASP_OFSH_ADDR;
  wire logic wr_clk  = reg_wr && reg_addr == ASP_CLK_ADDR;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_format_control_r   <= ASP_FMT_RST;
      slot_sharing_control_r  <= ASP_SLOT_RST;
      data_offset_low_r       <= ASP_OFS_RST;
      data_offset_high_r      <= ASP_OFS_RST;
      port_clocking_control_r <= ASP_CLK_RST;
    end else begin
      if (wr_fmt) port_format_control_r <= reg_wdata;
      if (wr_slot) slot_sharing_control_r <= reg_wdata & ASP_SLOT_WMSK;
      if (wr_ofsl) data_offset_low_r <= reg_wdata;
      if (wr_ofsh) data_offset_high_r <= reg_wdata & ASP_OFSH_WMSK;
      if (wr_clk) port_clocking_control_r <= reg_wdata & ASP_CLK_WMSK;
    end
  end

  always_comb begin
    if (reg_addr == ASP_FMT_ADDR) rd_nxt = port_format_control_r;
    else if (reg_addr == ASP_SLOT_ADDR) rd_nxt = slot_sharing_control_r;
    else if (reg_addr == ASP_OFSL_ADDR) rd_nxt = data_offset_low_r;
    else if (reg_addr == ASP_OFSH_ADDR) rd_nxt = data_offset_high_r;
    else if (reg_addr == ASP_CLK_ADDR) rd_nxt = port_clocking_control_r;
    else if (reg_addr == ASP_STAT_ADDR) rd_nxt = status_w;
    else rd_nxt = 8'h00;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) reg_rdata_r <= 8'h00;
    else if (reg_rd) reg_rdata_r <= rd_nxt;
  end
  assign reg_rdata = reg_rdata_r;

  // ***************************************
  // field decode
  // ***************************************
  wire logic       port_en   = port_format_control_r[ASP_EN_BIT];
  wire logic [2:0] active_channel_count =
    port_format_control_r[ASP_CHN_LSB +: 3];
  wire logic [11:0] wl12 =
    wl_bits(port_format_control_r[ASP_WL_LSB +: 2]);
  wire asp_fmt_e   fmt =
    asp_fmt_e'(port_format_control_r[ASP_FMT_LSB +: 2]);
  wire logic       tdm_en    = slot_sharing_control_r[ASP_TDM_BIT];
  wire logic       out_en    = slot_sharing_control_r[ASP_OE_BIT];
  wire logic [3:0] slot_channel_mask =
    slot_sharing_control_r[ASP_MASK_LSB +: 4];
  wire logic       master    = port_clocking_control_r[ASP_MST_BIT];
  wire logic       wclk_frc  = port_clocking_control_r[ASP_WTRI_BIT];
  wire logic       wclk_pol  = port_clocking_control_r[ASP_WPOL_BIT];
  wire logic       bclk_pol  = port_clocking_control_r[ASP_BPOL_BIT];
  wire logic [8:0] frame_len =
    9'd32 << port_clocking_control_r[ASP_BPW_LSB +: 2];
  wire logic [11:0] half12   = {4'h0, frame_len[8:1]};
  wire logic [11:0] ofs_w    =
    {1'b0, data_offset_high_r[2:0], data_offset_low_r};
  wire logic       fmt_i2s   = fmt == ASP_I2S;
  wire logic       fmt_dsp   = fmt == ASP_DSP;
  wire logic       wdrive    = master && !wclk_frc;

  // ***************************************
  // pin synchronisers
  // ***************************************
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= {serial_data_in, wclk_in, bclk_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ***************************************
  // master clock generation
  // ***************************************
  logic [15:0] div_r;
  logic        bclk_pin_r;
  logic [8:0]  fcnt_r;
  logic        wclk_pin_r;
  logic        bclk_q_r;
  logic        wclk_q_r;

  wire logic tick = master && div_r == 16'(BCLK_HALF - 1);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r      <= 16'h0000;
      bclk_pin_r <= 1'b0;
    end else if (!master) begin
      div_r      <= 16'h0000;
      bclk_pin_r <= bclk_pol;
    end else begin
      div_r      <= tick ? 16'h0000 : div_r + 16'h0001;
      if (tick) bclk_pin_r <= !bclk_pin_r;
    end
  end

  // ***************************************
  // edge detection
  // ***************************************
  wire logic bclk_lvl = master ? bclk_pin_r : pin_s2_r[0];
  wire logic wclk_lvl = wdrive ? wclk_pin_r : pin_s2_r[1];
  wire logic bclk_eff = bclk_lvl ^ bclk_pol;
  wire logic wclk_eff = wclk_lvl ^ wclk_pol ^ fmt_i2s;
  wire logic launch   = bclk_q_r && !bclk_eff;
  wire logic sample   = !bclk_q_r && bclk_eff;
  wire logic fstart   = sample && wclk_eff && !wclk_q_r;

  wire logic [8:0] fcnt_nxt =
    (fcnt_r >= frame_len - 9'd1) ? 9'h000 : fcnt_r + 9'h001;
  wire logic mark =
    fmt_dsp ? (fcnt_nxt == 9'h000) : (fcnt_nxt < frame_len[8:1]);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_q_r   <= 1'b0;
      wclk_q_r   <= 1'b0;
      fcnt_r     <= 9'h000;
      wclk_pin_r <= 1'b0;
    end else begin
      bclk_q_r <= bclk_eff;
      // while off, follow the pin so enabling finds no stale frame edge
      if (sample || !port_en) wclk_q_r <= wclk_eff;
      if (launch && master) begin
        fcnt_r     <= fcnt_nxt;
        wclk_pin_r <= mark ^ wclk_pol ^ fmt_i2s;
      end
    end
  end

  // ***************************************
  // frame position and slots
  // ***************************************
  logic [11:0] pos_r;
  logic [11:0] start_w [4];
  logic [3:0]  ch_on;
  logic [3:0]  in_l;
  logic [3:0]  first_l;
  logic [3:0]  in_s;
  logic [3:0]  last_s;
  logic [1:0]  rx_idx;

  wire logic [11:0] pos_nxt =
    (pos_r == ASP_POS_IDLE) ? pos_r : pos_r + 12'h001;
  wire logic [11:0] rj_base = (half12 > wl12) ? half12 - wl12 : 12'h000;
  wire logic [11:0] base_w  = (fmt == ASP_LJ) ? 12'h000 :
                              (fmt == ASP_RJ) ? rj_base : 12'h001;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) pos_r <= ASP_POS_IDLE;
    else if (!port_en) pos_r <= ASP_POS_IDLE;
    else if (fstart) pos_r <= ASP_POS_ARM;
    else if (launch) pos_r <= pos_nxt;
  end

  for (genvar k = 0; k < 4; k++) begin : g_slot
    assign start_w[k] = base_w + ofs_w +
      (fmt_dsp ? 12'(k) * wl12 :
       ((k % 2 == 1) ? half12 : 12'h000) +
       ((k / 2 == 1) ? wl12 : 12'h000));
    assign ch_on[k] = port_en &&
      (3'(k) < active_channel_count) &&
      (!tdm_en || slot_channel_mask[k]);
    assign in_l[k]    = ch_on[k] && in_win(pos_nxt, start_w[k], wl12);
    assign first_l[k] = ch_on[k] && pos_nxt == start_w[k];
    assign in_s[k]    = ch_on[k] && in_win(pos_r, start_w[k], wl12);
    assign last_s[k]  = ch_on[k] &&
      pos_r == start_w[k] + wl12 - 12'h001;
  end

  always_comb begin
    rx_idx = 2'b00;
    for (int i = 0; i < 4; i++) begin
      if (last_s[i]) rx_idx = 2'(i);
    end
  end

  // ***************************************
  // transmit path
  // ***************************************
  logic [31:0] fifo_data;
  logic        fifo_valid;
  logic [31:0] tx_sh_r;
  logic        sdo_r;
  logic        drive_r;

  wire logic        tx_load = launch && |first_l;
  wire logic [31:0] tx_word = fifo_valid ? fifo_data : 32'h0000_0000;

  asp_fifo #(
    .W (32),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (tx_load)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_sh_r <= 32'h0000_0000;
      sdo_r   <= 1'b0;
      drive_r <= 1'b0;
    end else if (launch) begin
      drive_r <= |in_l;
      if (tx_load) begin
        sdo_r   <= tx_word[31];
        tx_sh_r <= {tx_word[30:0], 1'b0};
      end else if (|in_l) begin
        sdo_r   <= tx_sh_r[31];
        tx_sh_r <= {tx_sh_r[30:0], 1'b0};
      end else begin
        sdo_r   <= 1'b0;
      end
    end
  end

  assign serial_data_out = sdo_r;
  assign sdo_oe_b =
    !(out_en && port_en && (!tdm_en || drive_r));

  // ***************************************
  // receive path
  // ***************************************
  logic [31:0] rx_sh_r;
  logic [31:0] rx_data_r;
  logic [1:0]  rx_chan_r;
  logic        rx_valid_r;

  wire logic [31:0] rx_full = {rx_sh_r[30:0], pin_s2_r[2]};
  wire logic        rx_done = sample && |last_s;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sh_r    <= 32'h0000_0000;
      rx_data_r  <= 32'h0000_0000;
      rx_chan_r  <= 2'b00;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= rx_done;
      if (sample && |in_s) rx_sh_r <= rx_full;
      if (rx_done) begin
        rx_data_r <= rx_full << (6'd32 - wl12[5:0]);
        rx_chan_r <= rx_idx;
      end
    end
  end

  assign rx_data  = rx_data_r;
  assign rx_chan  = rx_chan_r;
  assign rx_valid = rx_valid_r;

  // ***************************************
  // pin drivers and status
  // ***************************************
  assign bclk_out  = bclk_pin_r;
  assign bclk_oe_b = !master;
  assign wclk_out  = wclk_pin_r;
  assign wclk_oe_b = !wdrive;
  assign status_w  = {3'b000, !sdo_oe_b, wdrive, master,
                      !tx_ready, !fifo_valid};

  // ***************************************
  // assertions
  // ***************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_slot_float_idle:
    assert property (tdm_en && !drive_r |-> sdo_oe_b)
    else $error("data output driven outside a slot in shared mode");

  a_drive_off_hiz:
    assert property (!out_en |-> sdo_oe_b)
    else $error("data output driven while drive control is zero");

  a_mask_gates_slot:
    assert property (launch && tdm_en && (|in_l) |=>
                     drive_r && ((ch_on & ~slot_channel_mask) == 4'h0))
    else $error("masked channel reached the shared line");

  a_offset_load_pos:
    assert property (tx_load |-> pos_nxt >= base_w + ofs_w)
    else $error("word loaded before the programmed offset");

  a_master_clk_dir:
    assert property (master |-> !bclk_oe_b ##0 (wclk_frc || !wclk_oe_b))
    else $error("master mode does not drive its clocks");

  a_force_wclk_in:
    assert property (wclk_frc |-> wclk_oe_b)
    else $error("frame clock driven while forced to input");

  a_wclk_polarity:
    assert property (wdrive && fmt_dsp && $past(launch) &&
                     $stable(port_clocking_control_r) &&
                     $stable(port_format_control_r) &&
                     fcnt_r == 9'h000 |-> wclk_pin_r != wclk_pol)
    else $error("frame pulse has the wrong polarity");

  a_launch_edge:
    assert property (launch |-> bclk_lvl == bclk_pol ##1 !launch)
    else $error("data launched on the wrong bit clock edge");

  a_frame_wrap:
    assert property (launch && master && fcnt_r == frame_len - 9'd1
                     |=> fcnt_r == 9'h000)
    else $error("master frame length differs from setting");

  a_disabled_quiet:
    assert property (!port_en && !$past(port_en) |-> !rx_valid &&
                     sdo_oe_b && !tx_load)
    else $error("transfer while the port is disabled");

endmodule : asp_port
`default_nettype wire

// ---- tb/asp_host_model.sv ----
// asp_host_model: host end of the serial link, master of both link clocks
`timescale 1ns/10ps
`default_nettype none
module asp_host_model (
  // clock and control
  input  wire logic        ref_clk,
  input  wire logic        run,
  input  wire logic        bpol,
  input  wire logic        wlev,
  input  wire logic [63:0] ftx,
  // link pins
  input  wire logic        sdo,
  input  wire logic        sdo_oe_b,
  output logic             bclk,
  output logic             wclk,
  output logic             sdi,
  // captured frame
  output logic      [63:0] frx,
  output logic      [63:0] foe,
  output logic             done
);
  logic [2:0] c_r = 3'h0;
  logic [5:0] p_r = 6'h00;
  logic       eb_r = 1'b1;
  logic       lst_r = 1'b0;
  logic       wire_v;
  // a released data line shows a level that changes every cycle
  assign wire_v = sdo_oe_b ? ~lst_r : sdo;
  assign bclk   = eb_r ^ bpol;
  initial begin
    wclk = 1'b1;
    sdi  = 1'b0;
    done = 1'b0;
  end
  // clocks stand still while run is low
  always @(posedge ref_clk) begin
    lst_r <= wire_v;
    done  <= 1'b0;
    if (!run) begin
      c_r  <= 3'h0;
      p_r  <= 6'h00;
      eb_r <= 1'b1;
      wclk <= ~wlev;
    end else begin
      c_r <= c_r + 3'h1;
      if (c_r == 3'h0) begin
        eb_r <= 1'b0;
        wclk <= (p_r < 6'h20) ? wlev : ~wlev;
        sdi  <= ftx[6'h3F - p_r];
      end
      if (c_r == 3'h4) eb_r <= 1'b1;
      if (c_r == 3'h7) begin
        frx[6'h3F - p_r] <= wire_v;
        foe[6'h3F - p_r] <= sdo_oe_b;
        done <= (p_r == 6'h3F);
        p_r  <= p_r + 6'h01;
      end
    end
  end
endmodule : asp_host_model
`default_nettype wire

// ---- tb/asp_port_tb.sv ----
// asp_port_tb: self-checking bench of the audio serial port
`timescale 1ns/10ps
`default_nettype none
module asp_port_tb
  import asp_pkg::*;
;
  localparam logic [63:0] MSK = 64'h7FFF_FFFF_FFFF_FFFF;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        tx_valid = 1'b0;
  logic        run = 1'b0;
  logic        bpol = 1'b0;
  logic        wlev = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [31:0] tx_data = 32'h0;
  logic [63:0] ftx = 64'h0;
  logic [31:0] seed = 32'hCF27B377;
  logic [7:0]  reg_rdata;
  logic [31:0] rx_data;
  logic [1:0]  rx_chan;
  logic        rx_valid, tx_ready, bclk_out, bclk_oe_b, wclk_out, wclk_oe_b;
  logic        sdo, sdo_oe_b, hb, hw, sdi, done, bclk_w, wclk_w;
  logic [63:0] frx, foe;
  logic [33:0] rxq[$];
  logic [31:0] txq[$];
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  assign bclk_w = bclk_oe_b ? hb : bclk_out;
  assign wclk_w = wclk_oe_b ? hw : wclk_out;
  always #50 ref_clk = ~ref_clk;
  asp_port #(.BCLK_HALF(4), .FIFO_DEPTH(32)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_chan(rx_chan), .rx_valid(rx_valid),
    .bclk_in(bclk_w), .bclk_out(bclk_out), .bclk_oe_b(bclk_oe_b),
    .wclk_in(wclk_w), .wclk_out(wclk_out), .wclk_oe_b(wclk_oe_b),
    .serial_data_in(sdi), .serial_data_out(sdo), .sdo_oe_b(sdo_oe_b));
  asp_host_model host (
    .ref_clk(ref_clk), .run(run), .bpol(bpol), .wlev(wlev), .ftx(ftx),
    .sdo(sdo), .sdo_oe_b(sdo_oe_b), .bclk(hb), .wclk(hw), .sdi(sdi),
    .frx(frx), .foe(foe), .done(done));
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) rxq.push_back({rx_chan, rx_data});
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // frame bit 62-d carries device slot position d
  function automatic logic [63:0] fexp(logic [31:0] a, logic [31:0] b,
                                       int s1, int s2, int w);
    logic [63:0] r;
    r = '0;
    for (int k = 0; k < w; k++) begin
      r[62 - s1 - k] = a[31 - k];
      r[62 - s2 - k] = b[31 - k];
    end
    return r;
  endfunction : fexp
  function automatic logic [31:0] rexp(int s, int w);
    logic [31:0] r;
    r = '0;
    for (int k = 0; k < w; k++) r[31 - k] = ftx[62 - s - k];
    return r;
  endfunction : rexp
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [63:0] g, input logic [63:0] e, string m);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, string m);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    cmp(reg_rdata, e, m);
  endtask : rchk
  // port held off while the link setup and the host pins change
  task automatic cfg(input logic [7:0] fm, sl, of, ck);
    wr(ASP_FMT_ADDR, fm & 8'h7F);
    wr(ASP_SLOT_ADDR, sl);
    wr(ASP_OFSL_ADDR, of);
    wr(ASP_CLK_ADDR, ck);
    bpol = ck[2];
    wlev = ~(ck[3] ^ (fm[1:0] == 2'h0));
    // let the host pins settle through the synchronisers before enabling
    repeat (4) @(negedge ref_clk);
    wr(ASP_FMT_ADDR, fm);
  endtask : cfg
  task automatic frame();
    @(negedge ref_clk);
    run = 1'b1;
    @(posedge done);
    @(negedge ref_clk);
    run = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask : frame
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      $display("[ERR] %0t run too long", $time);
      tally_and_finish();
    end
  end
  initial begin
    int f, wc, w, o, n, s, s2, k;
    logic [31:0] a;
    logic [7:0] wm[4];
    logic pb, pw;
    wm = '{ASP_SLOT_WMSK, 8'hFF, ASP_OFSH_WMSK, ASP_CLK_WMSK};
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    rchk(ASP_FMT_ADDR, ASP_FMT_RST, "fmt reset");
    rchk(ASP_SLOT_ADDR, ASP_SLOT_RST, "slot reset");
    rchk(ASP_OFSL_ADDR, ASP_OFS_RST, "ofsl reset");
    rchk(ASP_OFSH_ADDR, ASP_OFS_RST, "ofsh reset");
    rchk(ASP_CLK_ADDR, ASP_CLK_RST, "clk reset");
    rchk(8'h50, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++) begin
      a = xs();
      wr(ASP_SLOT_ADDR + 8'(i), a[7:0]);
      rchk(ASP_SLOT_ADDR + 8'(i), a[7:0] & wm[i], "rw");
    end
    wr(ASP_OFSH_ADDR, 8'h00);
    cfg(8'h28, 8'h40, 8'h00, 8'h01);
    $display("test registers done");
    n = 0;
    while (n < 40) begin
      @(negedge ref_clk);
      if (tx_ready !== 1'b1) break;
      tx_data = xs();
      tx_valid = 1'b1;
      txq.push_back(tx_data);
      n++;
    end
    tx_valid = 1'b0;
    cmp(64'(n), 64'd32, "fifo depth");
    rchk(ASP_STAT_ADDR, 8'h02, "fifo full");
    $display("test fifo done");
    for (int i = 0; i < 16; i++) begin
      f = (i % 3 == 2) ? 3 : i % 3;
      wc = (i == 0) ? 2 : int'(xs() % 3);
      w = 16 + 4 * wc;
      s = (f != 1);
      o = (i == 1) ? 31 - w - s : int'(xs() % (32 - w - s));
      s = s + o;
      s2 = (f == 3) ? s + w : s + 32;
      a = xs();
      ftx = {xs(), xs()};
      cfg({2'h2, 2'h2, wc[1:0], f[1:0]}, 8'h40, 8'(o),
          {4'h0, a[1:0], 2'h1});
      n = rxq.size();
      frame();
      cmp(frx & MSK, fexp(txq[0], txq[1], s, s2, w) & MSK, "tx");
      cmp(foe & MSK, 64'h0, "oe normal");
      cmp(64'(rxq.size() - n), 64'd2, "rx count");
      cmp(rxq[n], {2'h0, rexp(s, w)}, "rx 1L");
      cmp(rxq[n + 1], {2'h1, rexp(s2, w)}, "rx 1R");
      void'(txq.pop_front());
      void'(txq.pop_front());
    end
    wr(ASP_FMT_ADDR, 8'h28);
    rchk(ASP_STAT_ADDR, 8'h01, "fifo empty");
    $display("test frames done");
    cfg(8'hB0, 8'hC5, 8'h00, 8'h01);
    n = rxq.size();
    frame();
    cmp(foe & MSK, 64'h4000_0000_3FFF_FFFF, "shared oe");
    cmp(64'(rxq.size() - n), 64'd2, "shared rx");
    cmp(rxq[$][33:32], 2'h2, "shared rx chan");
    cfg(8'hB0, 8'h85, 8'h00, 8'h01);
    frame();
    cmp(foe & MSK, MSK, "drive off");
    cfg(8'h28, 8'h40, 8'h00, 8'h01);
    n = rxq.size();
    frame();
    cmp(foe, 64'hFFFF_FFFF_FFFF_FFFF, "disabled oe");
    cmp(64'(rxq.size() - n), 64'd0, "disabled rx");
    $display("test slots done");
    for (int c = 0; c < 4; c++) begin
      // odd codes run the pulse framing, upper codes invert the frame clock
      cfg(8'h80 | 8'(3 * (c % 2)), 8'h40, 8'h00,
          8'h80 | 8'(c) | 8'(8 * (c / 2)));
      cmp({bclk_oe_b, wclk_oe_b}, 2'b00, "master oe");
      k = 0;
      n = 0;
      pb = bclk_out;
      pw = wclk_out;
      while (k < 2) begin
        @(negedge ref_clk);
        if (bclk_out === 1'b1 && pb === 1'b0 && k == 1) n++;
        if (wclk_out === 1'b1 && pw === 1'b0) k++;
        pb = bclk_out;
        pw = wclk_out;
      end
      cmp(64'(n), 64'(32 << c), "bclks per frame");
    end
    wr(ASP_CLK_ADDR, 8'h91);
    cmp({bclk_oe_b, wclk_oe_b}, 2'b01, "frame forced in");
    wr(ASP_CLK_ADDR, 8'h01);
    cmp({bclk_oe_b, wclk_oe_b}, 2'b11, "slave oe");
    $display("test master done");
    tally_and_finish();
  end
endmodule : asp_port_tb
`default_nettype wire
